// *** include/dtc_pkg.sv ***
// dual timer/counter package: register map, field positions, phases, step helper
// assumes one system clock; a machine cycle spans a fixed number of system clocks
package dtc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
	localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
	localparam logic [7:0] ADDR_U0_LOW = 8'h8A;
	localparam logic [7:0] ADDR_U1_LOW = 8'h8B;
	localparam logic [7:0] ADDR_U0_HIGH = 8'h8C;
	localparam logic [7:0] ADDR_U1_HIGH = 8'h8D;
	localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;
	localparam logic [7:0] ADDR_PORT3_MODE = 8'h96;

	localparam logic [7:0] RST_CTRL_FLAGS = 8'h00;
	localparam logic [7:0] RST_MODE_SEL = 8'h00;
	localparam logic [7:0] RST_CLK_SEL = 8'h00;
	localparam logic [7:0] RST_PORT3_MODE = 8'h00;
	localparam logic [7:0] RST_COUNT_BYTE = 8'h00;
	localparam logic RST_TOGGLE = 1'b0;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_U1_OVF = 7;
	localparam int CTRL_U1_RUN = 6;
	localparam int CTRL_U0_OVF = 5;
	localparam int CTRL_U0_RUN = 4;
	localparam int CLK_U1_DIV = 4;
	localparam int CLK_U0_DIV = 3;
	localparam logic [7:0] CLK_SEL_MASK = 8'h18;
	localparam int MODE_U1_GATE = 7;
	localparam int MODE_U1_FUNC = 6;
	localparam int MODE_U1_SEL = 4;
	localparam int MODE_U0_GATE = 3;
	localparam int MODE_U0_FUNC = 2;
	localparam int MODE_U0_SEL = 0;
	localparam int P3M_U1_TOGGLE = 3;
	localparam int P3M_U0_TOGGLE = 2;

	// ----------------------------------------------------------------
	// machine cycle timing (phase index 0 is the first phase)
	// ----------------------------------------------------------------
	localparam logic [3:0] MC_LAST_PHASE = 4'hB;
	localparam logic [3:0] PH_UPDATE = 4'h2;
	localparam logic [3:0] PH_SAMPLE = 4'h3;
	localparam logic [1:0] PH_FAST_TICK = 2'h2;

	localparam logic [1:0] MODE_PRESCALE = 2'h0;
	localparam logic [1:0] MODE_FULL16 = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic bit_wr;
		logic bit_rd;
		logic [2:0] bit_idx;
		logic bit_val;
	} dtc_bus_req_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic ovf;
	} dtc_step_t;

	// one increment of a unit in modes 0..2; mode 3 is handled by the caller
	function automatic dtc_step_t dtc_count_step(input logic [1:0] mode,
			input logic [15:0] cnt, input logic inc);
		dtc_step_t r;
		logic [16:0] sum;
		logic carry;
		r.cnt = cnt;
		r.ovf = 1'b0;
		sum = {1'b0, cnt} + 17'h00001;
		carry = &cnt[4:0];
		if (inc) begin
			case (mode)
				MODE_PRESCALE: begin
					r.cnt[4:0] = cnt[4:0] + 5'h01;
					r.cnt[15:8] = cnt[15:8] + {7'h00, carry};
					r.ovf = carry & (&cnt[15:8]);
				end
				MODE_FULL16: begin
					r.cnt = sum[15:0];
					r.ovf = sum[16];
				end
				MODE_RELOAD8: begin
					r.cnt[7:0] = (&cnt[7:0]) ? cnt[15:8] : sum[7:0];
					r.ovf = &cnt[7:0];
				end
				default: begin
					r.cnt = cnt;
				end
			endcase
		end
		return r;
	endfunction

endpackage

// *** logic/dtc_top.sv ***
// two 16-bit timer/counters with four modes, register port and toggle outputs
// assumes count and gate pins are asynchronous; register port is on ref_clk_i
//
// Overview of operation
// RQ1: each unit counts in a 16-bit value of two separately accessible bytes.
// RQ2: with toggling enabled, a unit's overflow inverts its toggle pin output.
// RQ3: each unit's toggle enable is its own bit of the port-3 mode register.
// RQ4: timer function divides system clock by 12, or by 4 when select set.
// RQ5: clock select for unit one at bit 4, unit zero at bit 3.
// RQ6: counter function increments on a falling edge of the count pin.
// RQ7: count pins are sampled once per machine cycle; high then low is an edge.
// RQ8: external counting never exceeds one twenty-fourth of the system clock.
// RQ9: counts update at the update phase; edges count the machine cycle after.
// RQ10: function select is mode bit 2 for unit zero, bit 6 for unit one.
// RQ11: unit one gate set means counting needs its interrupt input high too.
// RQ12: unit zero gate set means counting needs run and its interrupt input high.
// RQ13: mode 00 is an 8-bit upper counter behind a 5-bit lower prescaler.
// RQ14: mode 01 is a full 16-bit timer or counter.
// RQ15: mode 10 is an 8-bit lower counter reloaded from the upper byte.
// RQ16: mode 11 splits unit zero into two 8-bit parts, upper timer only.
// RQ17: mode 11 halts unit one.
// RQ18: control register allows bit and byte access and resets to zero.
// RQ19: overflow sets the unit's flag; counting only while its run bit is set.
// RQ20: in split mode unit zero's upper part uses unit one's run and flag.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module dtc_top
	import dtc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire dtc_bus_req_t bus_i,
	output logic [7:0] rd_data_o,
	input wire logic unit_zero_count_pin_i,
	input wire logic unit_one_count_pin_i,
	input wire logic ext_irq_zero_in_i,
	input wire logic ext_irq_one_in_i,
	output logic unit_zero_toggle_o,
	output logic unit_one_toggle_o
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic pin0_s;
	logic pin1_s;
	logic irq0_s;
	logic irq1_s;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pin_meta_q <= 4'hF;
			pin_sync_q <= 4'hF;
		end else begin
			pin_meta_q <= {ext_irq_one_in_i, ext_irq_zero_in_i,
				unit_one_count_pin_i, unit_zero_count_pin_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign pin0_s = pin_sync_q[0];
	assign pin1_s = pin_sync_q[1];
	assign irq0_s = pin_sync_q[2];
	assign irq1_s = pin_sync_q[3];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] mode_q;
	logic [7:0] clk_sel_q;
	logic [7:0] p3m_q;
	logic [15:0] cnt0_q;
	logic [15:0] cnt0_d;
	logic [15:0] cnt1_q;
	logic [15:0] cnt1_d;
	logic [7:0] rd_data_q;
	logic tgl0_q;
	logic tgl1_q;

	logic wr_en;
	logic [7:0] wr_addr;
	assign wr_en = bus_i.wr;
	assign wr_addr = bus_i.addr;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			mode_q <= RST_MODE_SEL;
			clk_sel_q <= RST_CLK_SEL;
			p3m_q <= RST_PORT3_MODE;
		end else if (wr_en) begin
			if (wr_addr == ADDR_MODE_SEL) begin
				mode_q <= bus_i.wdata;
			end
			if (wr_addr == ADDR_CLK_SEL) begin
				clk_sel_q <= bus_i.wdata & CLK_SEL_MASK; // [RQ5]
			end
			if (wr_addr == ADDR_PORT3_MODE) begin
				p3m_q <= bus_i.wdata; // [RQ3]
			end
		end
	end

	// ----------------------------------------------------------------
	// machine cycle phase and ticks
	// ----------------------------------------------------------------
	logic [3:0] phase_q;
	logic at_update;
	logic at_sample;
	logic fast_tick;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			phase_q <= 4'h0;
		end else if (phase_q == MC_LAST_PHASE) begin
			phase_q <= 4'h0;
		end else begin
			phase_q <= phase_q + 4'h1;
		end
	end

	assign at_update = (phase_q == PH_UPDATE);
	assign at_sample = (phase_q == PH_SAMPLE);
	// divide by 4 ticks three times a machine cycle, one of them at the update phase
	assign fast_tick = (phase_q[1:0] == PH_FAST_TICK);

	// ----------------------------------------------------------------
	// count pin edge detection
	// ----------------------------------------------------------------
	logic [1:0] samp_q;
	logic [1:0] pend_q;

	// sampling once per machine cycle caps external counting at 1/24 of the clock
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			samp_q <= 2'h0;
			pend_q <= 2'h0;
		end else if (at_sample) begin
			samp_q <= {pin1_s, pin0_s}; // [RQ7] [RQ8]
			pend_q <= samp_q & ~{pin1_s, pin0_s}; // [RQ6] [RQ7]
		end else if (at_update) begin
			pend_q <= 2'h0; // [RQ9]
		end
	end

	// ----------------------------------------------------------------
	// increment sources
	// ----------------------------------------------------------------
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic tick0;
	logic tick1;
	logic en0;
	logic en1;
	logic inc0;
	logic inc1;
	logic split0;

	assign mode0 = mode_q[MODE_U0_SEL +: 2];
	assign mode1 = mode_q[MODE_U1_SEL +: 2];
	assign split0 = (mode0 == MODE_SPLIT);
	assign tick0 = clk_sel_q[CLK_U0_DIV] ? fast_tick : at_update; // [RQ4]
	assign tick1 = clk_sel_q[CLK_U1_DIV] ? fast_tick : at_update; // [RQ4]
	assign en0 = ctrl_q[CTRL_U0_RUN] & (~mode_q[MODE_U0_GATE] | irq0_s); // [RQ12] [RQ19]
	assign en1 = ctrl_q[CTRL_U1_RUN] & (~mode_q[MODE_U1_GATE] | irq1_s); // [RQ11] [RQ19]
	// external edges are only applied at the update phase of the following cycle
	assign inc0 = en0 & (mode_q[MODE_U0_FUNC] ? (pend_q[0] & at_update) : tick0); // [RQ10]
	assign inc1 = en1 & (mode1 != MODE_SPLIT) // [RQ17]
		& (mode_q[MODE_U1_FUNC] ? (pend_q[1] & at_update) : tick1); // [RQ10]

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	dtc_step_t step0;
	dtc_step_t step1;
	logic ovf0;
	logic ovf1;
	logic split_hi_inc;
	logic split_hi_ovf;
	logic split_lo_ovf;

	assign step0 = dtc_count_step(mode0, cnt0_q, inc0); // [RQ13] [RQ14] [RQ15]
	assign step1 = dtc_count_step(mode1, cnt1_q, inc1); // [RQ13] [RQ14] [RQ15]
	// split upper byte borrows unit one's run bit, ignores gate and function
	assign split_hi_inc = split0 & ctrl_q[CTRL_U1_RUN] & tick0; // [RQ16] [RQ20]
	assign split_lo_ovf = split0 & inc0 & (&cnt0_q[7:0]);
	assign split_hi_ovf = split_hi_inc & (&cnt0_q[15:8]);
	assign ovf0 = split0 ? split_lo_ovf : step0.ovf;
	assign ovf1 = step1.ovf;

	always_comb begin
		cnt0_d = cnt0_q;
		if (split0) begin
			cnt0_d[7:0] = cnt0_q[7:0] + {7'h00, inc0}; // [RQ16]
			cnt0_d[15:8] = cnt0_q[15:8] + {7'h00, split_hi_inc}; // [RQ16]
		end else begin
			cnt0_d = step0.cnt;
		end
		if (wr_en && wr_addr == ADDR_U0_LOW) begin
			cnt0_d[7:0] = bus_i.wdata; // [RQ1]
		end
		if (wr_en && wr_addr == ADDR_U0_HIGH) begin
			cnt0_d[15:8] = bus_i.wdata; // [RQ1]
		end
	end

	always_comb begin
		cnt1_d = step1.cnt;
		if (wr_en && wr_addr == ADDR_U1_LOW) begin
			cnt1_d[7:0] = bus_i.wdata; // [RQ1]
		end
		if (wr_en && wr_addr == ADDR_U1_HIGH) begin
			cnt1_d[15:8] = bus_i.wdata; // [RQ1]
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			cnt0_q <= {RST_COUNT_BYTE, RST_COUNT_BYTE};
			cnt1_q <= {RST_COUNT_BYTE, RST_COUNT_BYTE};
		end else begin
			cnt0_q <= cnt0_d; // [RQ9]
			cnt1_q <= cnt1_d; // [RQ9]
		end
	end

	// ----------------------------------------------------------------
	// control register: byte and bit access, set beats clear
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_en && wr_addr == ADDR_CTRL_FLAGS) begin
			ctrl_d = bus_i.wdata; // [RQ18]
		end
		if (bus_i.bit_wr) begin
			ctrl_d[bus_i.bit_idx] = bus_i.bit_val; // [RQ18]
		end
		if (ovf0) begin
			ctrl_d[CTRL_U0_OVF] = 1'b1; // [RQ19]
		end
		// in split mode unit one no longer owns its flag
		if (split_hi_ovf || (ovf1 && !split0)) begin
			ctrl_d[CTRL_U1_OVF] = 1'b1; // [RQ19] [RQ20]
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q <= RST_CTRL_FLAGS; // [RQ18]
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// toggle outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tgl0_q <= RST_TOGGLE;
			tgl1_q <= RST_TOGGLE;
		end else begin
			if (ovf0 && p3m_q[P3M_U0_TOGGLE]) begin
				tgl0_q <= ~tgl0_q; // [RQ2] [RQ3]
			end
			if (ovf1 && p3m_q[P3M_U1_TOGGLE]) begin
				tgl1_q <= ~tgl1_q; // [RQ2] [RQ3]
			end
		end
	end

	assign unit_zero_toggle_o = tgl0_q;
	assign unit_one_toggle_o = tgl1_q;

	// ----------------------------------------------------------------
	// read port: data stand one cycle after the strobe
	// ----------------------------------------------------------------
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			ADDR_CTRL_FLAGS: rd_mux = ctrl_q;
			ADDR_MODE_SEL: rd_mux = mode_q;
			ADDR_U0_LOW: rd_mux = cnt0_q[7:0];
			ADDR_U1_LOW: rd_mux = cnt1_q[7:0];
			ADDR_U0_HIGH: rd_mux = cnt0_q[15:8];
			ADDR_U1_HIGH: rd_mux = cnt1_q[15:8];
			ADDR_CLK_SEL: rd_mux = clk_sel_q;
			ADDR_PORT3_MODE: rd_mux = p3m_q;
			default: rd_mux = 8'h00;
		endcase
	endfunction

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rd_data_q <= 8'h00;
		end else if (bus_i.rd) begin
			rd_data_q <= rd_mux(bus_i.addr);
		end else if (bus_i.bit_rd) begin
			rd_data_q <= {7'h00, ctrl_q[bus_i.bit_idx]}; // [RQ18]
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	assign rd_data_o = rd_data_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic sw_cnt0;
	logic sw_cnt1;
	assign sw_cnt0 = wr_en && (wr_addr == ADDR_U0_LOW || wr_addr == ADDR_U0_HIGH);
	assign sw_cnt1 = wr_en && (wr_addr == ADDR_U1_LOW || wr_addr == ADDR_U1_HIGH);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_clksel_read_back: assert property ( // [RQ5]
		bus_i.rd && bus_i.addr == ADDR_CLK_SEL |=> rd_data_o[7:5] == 3'h0
			&& rd_data_o[2:0] == 3'h0 && rd_data_o[4:3] == $past(clk_sel_q[4:3]))
		else $error("clock select read back wrong");

	a_toggle_on_ovf: assert property ( // [RQ2]
		ovf0 && p3m_q[P3M_U0_TOGGLE] |=> unit_zero_toggle_o != $past(unit_zero_toggle_o))
		else $error("unit zero toggle missed overflow");

	a_toggle_disabled_hold: assert property ( // [RQ3]
		!p3m_q[P3M_U1_TOGGLE] |=> $stable(unit_one_toggle_o))
		else $error("unit one toggle moved while disabled");

	a_slow_update_phase: assert property ( // [RQ9]
		!clk_sel_q[CLK_U0_DIV] && !sw_cnt0 && cnt0_d != cnt0_q |-> phase_q == PH_UPDATE)
		else $error("unit zero count changed outside update phase");

	a_edge_sample_phase: assert property ( // [RQ7]
		$rose(pend_q[0]) |-> $past(phase_q) == PH_SAMPLE && $past(pin0_s, 1) == 1'b0)
		else $error("edge recognised off the sample phase");

	a_edge_next_cycle: assert property ( // [RQ6]
		mode_q[MODE_U0_FUNC] && en0 && mode0 == MODE_FULL16 && !sw_cnt0
			&& cnt0_d != cnt0_q |-> pend_q[0] && at_update)
		else $error("external count without a pending edge");

	a_halt_unit_one: assert property ( // [RQ17]
		mode1 == MODE_SPLIT && !sw_cnt1 |=> $stable(cnt1_q))
		else $error("unit one counted while halted");

	a_stopped_unit_zero: assert property ( // [RQ19]
		!ctrl_q[CTRL_U0_RUN] && !split0 && !sw_cnt0 |=> $stable(cnt0_q))
		else $error("unit zero counted without run");

	a_ovf_sets_flag: assert property ( // [RQ19]
		ovf0 |=> ctrl_q[CTRL_U0_OVF])
		else $error("unit zero overflow flag not set");

	a_reload_from_high: assert property ( // [RQ15]
		mode1 == MODE_RELOAD8 && ovf1 && !sw_cnt1 |=> cnt1_q[7:0] == $past(cnt1_q[15:8]))
		else $error("unit one reload value wrong");

	a_gate_blocks_unit: assert property ( // [RQ11]
		mode_q[MODE_U1_GATE] && !irq1_s && !sw_cnt1 |=> $stable(cnt1_q))
		else $error("gated unit one counted with input low");

	a_div12_rate: assert property ( // [RQ4]
		!mode_q[MODE_U0_FUNC] && !clk_sel_q[CLK_U0_DIV] && mode0 == MODE_FULL16 && en0
			&& !sw_cnt0 && at_update |=> cnt0_q == $past(cnt0_q) + 16'h0001)
		else $error("divide by 12 tick missed");

	c_ovf_zero: cover property (ovf0 && p3m_q[P3M_U0_TOGGLE]);
	c_reload_one: cover property (mode1 == MODE_RELOAD8 && ovf1);
	c_ext_edge: cover property (mode_q[MODE_U0_FUNC] && inc0);
	c_split_hi: cover property (split_hi_ovf);

endmodule // dtc_top

// *** tb/dtc_pin_model.sv ***
// far-side model: count pins and gate inputs of both timer units
// assumes tasks are called right after a rising edge of ref_clk_i
`timescale 1ns/1ps

module dtc_pin_model (
	input wire logic ref_clk_i,
	output logic unit_zero_count_pin_o,
	output logic unit_one_count_pin_o,
	output logic ext_irq_zero_in_o,
	output logic ext_irq_one_in_o
);
	initial begin
		unit_zero_count_pin_o = 1'b1;
		unit_one_count_pin_o = 1'b1;
		ext_irq_zero_in_o = 1'b0;
		ext_irq_one_in_o = 1'b0;
	end

	task automatic gate(input logic z, input logic o);
		ext_irq_zero_in_o <= z;
		ext_irq_one_in_o <= o;
	endtask

	task automatic set_pin(input logic u, input logic v);
		if (u) begin
			unit_one_count_pin_o <= v;
		end else begin
			unit_zero_count_pin_o <= v;
		end
	endtask

	// each level lasts a full machine cycle so no edge can slip between samples
	task automatic pulse(input logic u, input int n);
		for (int i = 0; i < n; i++) begin
			set_pin(u, 1'b0);
			repeat (12) @(posedge ref_clk_i);
			set_pin(u, 1'b1);
			repeat (12) @(posedge ref_clk_i);
		end
	endtask
endmodule // dtc_pin_model

// *** tb/dtc_top_tb_top.sv ***
// bench for the dual timer/counter: bus driver, read watcher, scenarios
// assumes dtc_pin_model stands in for the count pins and gate inputs
`timescale 1ns/1ps

module dtc_top_tb_top
	import dtc_pkg::*;
;
	logic ref_clk_i;
	logic rst_n_i;
	dtc_bus_req_t bus;
	logic [7:0] rd_data;
	logic p0, p1, g0, g1, tog0, tog1, t0p, t1p;
	logic rd_pend;
	logic [7:0] exp_q[$];
	logic [7:0] r;
	int err_total, samples_checked, seed, k, n, m, tog0_n, tog1_n;
	logic [7:0] ra[9] = '{ADDR_CTRL_FLAGS, ADDR_MODE_SEL, ADDR_CLK_SEL, ADDR_PORT3_MODE,
		ADDR_U0_LOW, ADDR_U0_HIGH, ADDR_U1_LOW, ADDR_U1_HIGH, 8'h80};

	dtc_top DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rd_data_o(rd_data),
		.unit_zero_count_pin_i(p0), .unit_one_count_pin_i(p1), .ext_irq_zero_in_i(g0),
		.ext_irq_one_in_i(g1), .unit_zero_toggle_o(tog0), .unit_one_toggle_o(tog1));

	dtc_pin_model pins (.ref_clk_i(ref_clk_i), .unit_zero_count_pin_o(p0),
		.unit_one_count_pin_o(p1), .ext_irq_zero_in_o(g0), .ext_irq_one_in_o(g1));

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// ----------------------------------------------------------------
	// bus tasks: wr, rd, bwr and brd each drive one request and let one edge take it
	// ----------------------------------------------------------------
	task automatic drive(input dtc_bus_req_t q);
		bus <= q;
		@(posedge ref_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		drive('{addr: a, wdata: d, wr: 1'b1, default: '0});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		drive('{addr: a, rd: 1'b1, default: '0});
	endtask
	task automatic bwr(input logic [2:0] i, input logic v);
		drive('{addr: ADDR_CTRL_FLAGS, bit_wr: 1'b1, bit_idx: i, bit_val: v, default: '0});
	endtask
	task automatic brd(input logic [2:0] i, input logic e);
		exp_q.push_back({7'h00, e});
		drive('{addr: ADDR_CTRL_FLAGS, bit_rd: 1'b1, bit_idx: i, default: '0});
	endtask
	task automatic idle(input int c);
		drive('0);
		repeat (c - 1) @(posedge ref_clk_i);
	endtask
	task automatic clr();
		wr(ADDR_U0_LOW, 8'h00);
		wr(ADDR_U0_HIGH, 8'h00);
		wr(ADDR_U1_LOW, 8'h00);
		wr(ADDR_U1_HIGH, 8'h00);
	endtask
	// run the units whose run bits are set in control byte c for exactly 12*k edges
	task automatic run(input logic [7:0] c, input int kk);
		wr(ADDR_CTRL_FLAGS, c);
		idle(12 * kk - 1);
		wr(ADDR_CTRL_FLAGS, 8'h00);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] e, input string s);
		samples_checked++;
		if (got !== e) begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, s, got, e);
		end
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watcher: read data stands only in the cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		if (rd_pend === 1'b1) begin
			chk(rd_data, exp_q.pop_front(), "read");
		end
		rd_pend <= bus.rd | bus.bit_rd;
		t0p <= tog0;
		t1p <= tog1;
		if (rst_n_i === 1'b1 && t0p !== tog0) begin
			tog0_n++;
		end
		if (rst_n_i === 1'b1 && t1p !== tog1) begin
			tog1_n++;
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		results();
	end

	initial begin
		seed = 32'h6349;
		err_total = 0;
		samples_checked = 0;
		rd_pend = 1'b0;
		bus = '0;
		rst_n_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		foreach (ra[i]) rd(ra[i], 8'h00);
		wr(ADDR_CLK_SEL, 8'hFF);
		rd(ADDR_CLK_SEL, CLK_SEL_MASK);
		$display("test reset_and_clksel done");

		k = 1 + ($unsigned($random(seed)) % 16);
		r = 8'($random(seed));
		wr(ADDR_MODE_SEL, 8'h10);
		wr(ADDR_U0_LOW, r);
		run(8'h50, k);
		rd(ADDR_U1_LOW, 8'(3 * k));
		rd(ADDR_U0_LOW, {r[7:5], 5'((r[4:0] + 3 * k) % 32)});
		rd(ADDR_U0_HIGH, 8'((r[4:0] + 3 * k) / 32));
		$display("test div4_prescale done");

		wr(ADDR_CLK_SEL, 8'h00);
		clr();
		wr(ADDR_MODE_SEL, 8'h99);
		pins.gate(1'b1, 1'b0);
		idle(4);
		run(8'h50, k);
		rd(ADDR_U0_LOW, 8'(k));
		rd(ADDR_U1_LOW, 8'h00);
		pins.gate(1'b0, 1'b1);
		idle(4);
		run(8'h50, k);
		rd(ADDR_U0_LOW, 8'(k));
		rd(ADDR_U1_LOW, 8'(k));
		$display("test gate done");

		n = 1 + ($unsigned($random(seed)) % 8);
		m = 1 + ($unsigned($random(seed)) % 8);
		clr();
		wr(ADDR_MODE_SEL, 8'h55);
		wr(ADDR_CTRL_FLAGS, 8'h50);
		idle(1);
		pins.pulse(1'b0, n);
		pins.pulse(1'b1, m);
		idle(40);
		wr(ADDR_CTRL_FLAGS, 8'h00);
		rd(ADDR_U0_LOW, 8'(n));
		rd(ADDR_U1_LOW, 8'(m));
		$display("test pin_count done");

		wr(ADDR_MODE_SEL, 8'h21);
		wr(ADDR_PORT3_MODE, 8'h08);
		wr(ADDR_U1_HIGH, 8'hFE);
		wr(ADDR_U1_LOW, 8'hFE);
		wr(ADDR_U0_LOW, 8'hFF);
		wr(ADDR_U0_HIGH, 8'hFF);
		tog0_n = 0;
		tog1_n = 0;
		bwr(3'h6, 1'b1);
		bwr(3'h4, 1'b1);
		idle(58);
		bwr(3'h6, 1'b0);
		bwr(3'h4, 1'b0);
		rd(ADDR_CTRL_FLAGS, 8'hA0);
		rd(ADDR_U1_LOW, 8'hFF);
		rd(ADDR_U0_LOW, 8'h04);
		rd(ADDR_U0_HIGH, 8'h00);
		brd(3'h7, 1'b1);
		bwr(3'h7, 1'b0);
		rd(ADDR_CTRL_FLAGS, 8'h20);
		idle(2);
		chk(8'(tog1_n), 8'h02, "toggle one");
		chk(8'(tog0_n), 8'h00, "toggle zero");
		$display("test overflow_toggle done");

		// unit zero reloads with its toggle enabled, unit one prescales with its toggle off
		wr(ADDR_CTRL_FLAGS, 8'h00);
		wr(ADDR_MODE_SEL, 8'h02);
		wr(ADDR_PORT3_MODE, 8'h04);
		wr(ADDR_U0_HIGH, 8'hFD);
		wr(ADDR_U0_LOW, 8'hFE);
		wr(ADDR_U1_LOW, 8'hFE);
		wr(ADDR_U1_HIGH, 8'hFF);
		tog0_n = 0;
		tog1_n = 0;
		run(8'h50, 4);
		rd(ADDR_U0_LOW, 8'hFF);
		rd(ADDR_U0_HIGH, 8'hFD);
		rd(ADDR_U1_LOW, 8'hE2);
		rd(ADDR_U1_HIGH, 8'h00);
		idle(2);
		chk(8'(tog0_n), 8'h01, "toggle zero reload");
		chk(8'(tog1_n), 8'h00, "toggle one off");
		$display("test reload_prescale done");

		wr(ADDR_CTRL_FLAGS, 8'h00);
		clr();
		wr(ADDR_MODE_SEL, 8'h33);
		run(8'h40, k);
		rd(ADDR_U0_HIGH, 8'(k));
		rd(ADDR_U0_LOW, 8'h00);
		rd(ADDR_U1_LOW, 8'h00);
		run(8'h10, k);
		rd(ADDR_U0_LOW, 8'(k));
		rd(ADDR_U0_HIGH, 8'(k));
		// one machine cycle of unit one's run bit overflows the split upper byte
		wr(ADDR_U0_HIGH, 8'hFF);
		bwr(3'h6, 1'b1);
		idle(11);
		bwr(3'h6, 1'b0);
		brd(3'h7, 1'b1);
		brd(3'h5, 1'b0);
		$display("test split_halt done");

		// a second reset in mid-run must bring back the control, mode, unit zero upper byte and toggle zero reset values
		rst_n_i <= 1'b0;
		idle(2);
		rst_n_i <= 1'b1;
		rd(ADDR_CTRL_FLAGS, RST_CTRL_FLAGS);
		rd(ADDR_MODE_SEL, RST_MODE_SEL);
		rd(ADDR_U0_HIGH, RST_COUNT_BYTE);
		idle(3);
		chk(8'(tog0), 8'h00, "toggle after reset");
		$display("test mid_reset done");
		results();
	end
endmodule // dtc_top_tb_top
